// *** hdl/nfc_bus_cycle.sv ***
// Purpose: Runs one asynchronous flash read or write cycle
// Assumes: Flash pins change only on pclk edges
// Notes: Chip select falls and rises together with write enable or output enable
`timescale 1ns/1ps
module nfc_bus_cycle
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire nfc_pkg::nfc_cyc_s cyc,
  output logic done,
  output logic [15:0] rdata,
  output logic [25:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  typedef enum logic [1:0] {BC_IDLE, BC_ACTIVE, BC_RECOVER} nfc_bc_e;
  nfc_bc_e st_q;
  logic [3:0] cnt_q;
  logic wr_q;
  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  // Address and data are set on the same edge as the strobes fall,
  // and the address stays stable until the strobes rise again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= BC_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      fl_addr <= '0;
      fl_dq_o <= 16'h0000;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      rdata <= 16'h0000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (st_q)
        BC_IDLE:
          if (start)
          begin
            st_q <= BC_ACTIVE;
            wr_q <= cyc.wr;
            fl_addr <= cyc.addr;
            fl_dq_o <= cyc.data;
            fl_dq_oe <= cyc.wr;
            fl_ce_n <= 1'b0;
            fl_we_n <= !cyc.wr;
            fl_oe_n <= cyc.wr;
            cnt_q <= cyc.wr ? 4'(nfc_pkg::WE_LOW_CYC)
                            : 4'(nfc_pkg::READ_CYC);
          end
        BC_ACTIVE:
          if (cnt_q == 4'h1)
          begin
            // Value latches at the first rising strobe edge
            fl_ce_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            if (!wr_q)
              rdata <= fl_dq_i; // Array read needs no prior writes
            cnt_q <= 4'(nfc_pkg::WE_HIGH_CYC);
            st_q <= BC_RECOVER;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        BC_RECOVER:
          if (cnt_q == 4'h1)
          begin
            fl_dq_oe <= 1'b0; // Hold data until strobes high, then free
            done <= 1'b1;
            st_q <= BC_IDLE;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        default:
          st_q <= BC_IDLE;
      endcase
    end
  end
endmodule : nfc_bus_cycle

// *** hdl/nfc_host.sv ***
// Purpose: APB-controlled host that issues flash command sequences
// Assumes: One operation at a time; software polls STATUS
// Notes: Unlock cycles use zero upper byte and zero high address
`timescale 1ns/1ps
module nfc_host
#(
  parameter int ADDR_W = 26,
  parameter int SECTOR_LSB = 16,
  parameter int BUF_PAGE_W = 5
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [25:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [4:0] op_q;
  logic [25:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic busy_q, done_q, refused_q;
  nfc_pkg::nfc_dev_e dev_q;
  logic [2:0] step_q;
  logic [2:0] nsteps_q;
  logic [5:0] buf_left_q;
  logic [25:0] buf_page_q;
  logic cyc_start_q;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  nfc_pkg::nfc_cyc_s cur_cyc;

  // Command-cycle builder: high address cleared, upper byte zero
  function automatic nfc_pkg::nfc_cyc_s cmd(input logic [11:0] a,
                                            input logic [7:0] d);
    nfc_pkg::nfc_cyc_s c;
    c.wr = 1'b1;
    c.addr = {14'h0000, a};
    c.data = {8'h00, d};
    return c;
  endfunction : cmd

  // Cycle carrying a full location and value
  function automatic nfc_pkg::nfc_cyc_s full(input logic w,
                                             input logic [25:0] a,
                                             input logic [15:0] d);
    nfc_pkg::nfc_cyc_s c;
    c.wr = w;
    c.addr = a;
    c.data = d;
    return c;
  endfunction : full

  // ****************************************************************
  // APB slave decode
  // ****************************************************************
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite;
  wire hit_ctrl = (paddr == nfc_pkg::REG_CTRL);
  wire hit_addr = (paddr == nfc_pkg::REG_ADDR);
  wire hit_wdata = (paddr == nfc_pkg::REG_WDATA);
  wire hit_status = (paddr == nfc_pkg::REG_STATUS);
  wire hit_rdata = (paddr == nfc_pkg::REG_RDATA);
  wire hit_mode = (paddr == nfc_pkg::REG_MODE);
  wire hit_any = hit_ctrl || hit_addr || hit_wdata || hit_status ||
                 hit_rdata || hit_mode;
  wire go = apb_wr && hit_ctrl && pwdata[nfc_pkg::CTRL_GO_BIT] && !busy_q;
  wire [4:0] go_op = pwdata[4:0];
  wire [31:0] status_word = {29'h0, refused_q, done_q, busy_q};
  assign pready = 1'b1; // Zero wait states
  assign pslverr = apb_acc && !hit_any;
  assign prdata = hit_ctrl ? {27'h0, op_q} :
                  hit_addr ? {6'h0, addr_q} :
                  hit_wdata ? {16'h0, wdata_q} :
                  hit_status ? status_word :
                  hit_rdata ? {16'h0, rdata_q} :
                  hit_mode ? {29'h0, dev_q} : 32'h0;

  // ****************************************************************
  // Legality check against the tracked device state
  // ****************************************************************
  // Illegal requests are refused rather than sent, since a stray
  // sequence leaves the device undefined
  logic legal;
  logic [2:0] steps;
  always_comb
  begin
    legal = 1'b1;
    steps = 3'd1;
    case (nfc_pkg::nfc_op_e'(go_op))
      nfc_pkg::OP_READ: legal = (dev_q != nfc_pkg::DM_BUF_LOAD);
      nfc_pkg::OP_RESET: legal = (dev_q != nfc_pkg::DM_BYPASS);
      nfc_pkg::OP_AUTOSEL_ENTER:
      begin
        legal = (dev_q == nfc_pkg::DM_ARRAY) ||
                (dev_q == nfc_pkg::DM_SUSPENDED);
        steps = 3'd3;
      end
      nfc_pkg::OP_QUERY:
        legal = (dev_q == nfc_pkg::DM_ARRAY) ||
                (dev_q == nfc_pkg::DM_AUTOSEL);
      nfc_pkg::OP_PROGRAM:
      begin
        legal = (dev_q == nfc_pkg::DM_ARRAY) ||
                (dev_q == nfc_pkg::DM_SUSPENDED);
        steps = 3'd4;
      end
      nfc_pkg::OP_BUF_START:
      begin
        legal = (dev_q == nfc_pkg::DM_ARRAY) &&
                (wdata_q < 16'(nfc_pkg::BUF_WORDS));
        steps = 3'd4;
      end
      nfc_pkg::OP_BUF_WORD:
        legal = (dev_q == nfc_pkg::DM_BUF_LOAD) && (buf_left_q != 6'h0) &&
                (addr_q[25:BUF_PAGE_W] == buf_page_q[25:BUF_PAGE_W]);
      nfc_pkg::OP_BUF_CONFIRM:
        legal = (dev_q == nfc_pkg::DM_BUF_LOAD) && (buf_left_q == 6'h0);
      nfc_pkg::OP_ABORT_RESET: steps = 3'd3;
      nfc_pkg::OP_BYPASS_ENTER:
      begin
        legal = (dev_q == nfc_pkg::DM_ARRAY);
        steps = 3'd3;
      end
      nfc_pkg::OP_BYPASS_PROG, nfc_pkg::OP_BYPASS_SECTOR_ERASE,
      nfc_pkg::OP_BYPASS_CHIP_ERASE, nfc_pkg::OP_BYPASS_EXIT:
      begin
        legal = (dev_q == nfc_pkg::DM_BYPASS);
        steps = 3'd2;
      end
      nfc_pkg::OP_CHIP_ERASE, nfc_pkg::OP_SECTOR_ERASE:
      begin
        legal = (dev_q == nfc_pkg::DM_ARRAY);
        steps = 3'd6;
      end
      nfc_pkg::OP_SUSPEND: legal = (dev_q == nfc_pkg::DM_ERASING);
      nfc_pkg::OP_RESUME: legal = (dev_q == nfc_pkg::DM_SUSPENDED);
      nfc_pkg::OP_SECSI_ENTER:
      begin
        legal = (dev_q == nfc_pkg::DM_ARRAY);
        steps = 3'd3;
      end
      nfc_pkg::OP_SECSI_EXIT:
      begin
        legal = (dev_q == nfc_pkg::DM_SECSI);
        steps = 3'd4;
      end
      default: legal = 1'b0;
    endcase
  end

  // ****************************************************************
  // Cycle selection for the current step
  // ****************************************************************
  wire [25:0] sec_addr = {addr_q[25:SECTOR_LSB], SECTOR_LSB'(0)};
  always_comb
  begin
    cur_cyc = step_q[0] ? cmd(nfc_pkg::ADDR_U2, nfc_pkg::CMD_UNLOCK2)
                        : cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_UNLOCK1);
    case (nfc_pkg::nfc_op_e'(op_q))
      nfc_pkg::OP_READ: cur_cyc = full(1'b0, addr_q, 16'h0000);
      nfc_pkg::OP_RESET:
        cur_cyc = cmd(12'h000, nfc_pkg::CMD_RESET);
      nfc_pkg::OP_AUTOSEL_ENTER:
        if (step_q == 3'd2)
          cur_cyc = cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_AUTOSEL);
      nfc_pkg::OP_QUERY:
        cur_cyc = cmd(nfc_pkg::ADDR_QUERY, nfc_pkg::CMD_QUERY);
      nfc_pkg::OP_PROGRAM:
        if (step_q == 3'd2)
          cur_cyc = cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_PROG);
        else if (step_q == 3'd3)
          cur_cyc = full(1'b1, addr_q, wdata_q);
      nfc_pkg::OP_BUF_START:
        if (step_q == 3'd2)
          cur_cyc = full(1'b1, sec_addr, {8'h00, nfc_pkg::CMD_BUF_LOAD});
        else if (step_q == 3'd3)
          cur_cyc = full(1'b1, sec_addr, wdata_q);
      nfc_pkg::OP_BUF_WORD: cur_cyc = full(1'b1, addr_q, wdata_q);
      nfc_pkg::OP_BUF_CONFIRM:
        cur_cyc = full(1'b1, sec_addr, {8'h00, nfc_pkg::CMD_BUF_CONFIRM});
      nfc_pkg::OP_ABORT_RESET:
        if (step_q == 3'd2)
          cur_cyc = cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_RESET);
      nfc_pkg::OP_BYPASS_ENTER:
        if (step_q == 3'd2)
          cur_cyc = cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_BYPASS);
      nfc_pkg::OP_BYPASS_PROG:
        cur_cyc = step_q[0] ? full(1'b1, addr_q, wdata_q)
                            : cmd(12'h000, nfc_pkg::CMD_PROG);
      nfc_pkg::OP_BYPASS_SECTOR_ERASE:
        cur_cyc = step_q[0]
          ? full(1'b1, sec_addr, {8'h00, nfc_pkg::CMD_SECTOR_ERASE})
          : cmd(12'h000, nfc_pkg::CMD_ERASE_SETUP);
      nfc_pkg::OP_BYPASS_CHIP_ERASE:
        cur_cyc = step_q[0] ? cmd(12'h000, nfc_pkg::CMD_CHIP_ERASE)
                            : cmd(12'h000, nfc_pkg::CMD_ERASE_SETUP);
      nfc_pkg::OP_BYPASS_EXIT:
        cur_cyc = step_q[0] ? cmd(12'h000, nfc_pkg::CMD_EXIT_DATA)
                            : cmd(12'h000, nfc_pkg::CMD_AUTOSEL);
      nfc_pkg::OP_CHIP_ERASE, nfc_pkg::OP_SECTOR_ERASE:
        if (step_q == 3'd2)
          cur_cyc = cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_ERASE_SETUP);
        else if (step_q == 3'd3)
          cur_cyc = cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_UNLOCK1);
        else if (step_q == 3'd4)
          cur_cyc = cmd(nfc_pkg::ADDR_U2, nfc_pkg::CMD_UNLOCK2);
        else if (step_q == 3'd5)
          cur_cyc = (op_q == 5'(nfc_pkg::OP_CHIP_ERASE))
            ? cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_CHIP_ERASE)
            : full(1'b1, sec_addr, {8'h00, nfc_pkg::CMD_SECTOR_ERASE});
      nfc_pkg::OP_SUSPEND:
        cur_cyc = cmd(12'h000, nfc_pkg::CMD_SUSPEND);
      nfc_pkg::OP_RESUME:
        cur_cyc = cmd(12'h000, nfc_pkg::CMD_RESUME);
      nfc_pkg::OP_SECSI_ENTER:
        if (step_q == 3'd2)
          cur_cyc = cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_SECSI);
      nfc_pkg::OP_SECSI_EXIT:
        if (step_q == 3'd2)
          cur_cyc = cmd(nfc_pkg::ADDR_U1, nfc_pkg::CMD_AUTOSEL);
        else if (step_q == 3'd3)
          cur_cyc = cmd(12'h000, nfc_pkg::CMD_EXIT_DATA);
      default: cur_cyc = cmd(12'h000, nfc_pkg::CMD_RESET);
    endcase
  end

  // Device state after the sequence completes
  logic [2:0] dev_next;
  always_comb
  begin
    dev_next = dev_q;
    case (nfc_pkg::nfc_op_e'(op_q))
      nfc_pkg::OP_RESET, nfc_pkg::OP_ABORT_RESET, nfc_pkg::OP_BYPASS_EXIT,
      nfc_pkg::OP_SECSI_EXIT: dev_next = nfc_pkg::DM_ARRAY;
      nfc_pkg::OP_AUTOSEL_ENTER: dev_next = nfc_pkg::DM_AUTOSEL;
      nfc_pkg::OP_QUERY: dev_next = nfc_pkg::DM_QUERY;
      nfc_pkg::OP_BUF_START: dev_next = nfc_pkg::DM_BUF_LOAD;
      nfc_pkg::OP_BUF_CONFIRM: dev_next = nfc_pkg::DM_ARRAY;
      nfc_pkg::OP_BYPASS_ENTER: dev_next = nfc_pkg::DM_BYPASS;
      nfc_pkg::OP_SECTOR_ERASE: dev_next = nfc_pkg::DM_ERASING;
      nfc_pkg::OP_SUSPEND: dev_next = nfc_pkg::DM_SUSPENDED;
      nfc_pkg::OP_RESUME: dev_next = nfc_pkg::DM_ERASING;
      nfc_pkg::OP_SECSI_ENTER: dev_next = nfc_pkg::DM_SECSI;
      default: dev_next = dev_q;
    endcase
  end
  wire last_step = cyc_done && (step_q == nsteps_q - 3'd1);

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_q <= 5'h00;
      addr_q <= '0;
      wdata_q <= 16'h0000;
      refused_q <= 1'b0;
    end
    else
    begin
      if (apb_wr && hit_addr && !busy_q)
        addr_q <= pwdata[25:0];
      if (apb_wr && hit_wdata && !busy_q)
        wdata_q <= pwdata[15:0];
      if (go)
        op_q <= go_op;
      if (apb_wr && hit_ctrl && pwdata[nfc_pkg::CTRL_GO_BIT])
        refused_q <= busy_q || !legal;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Sector erase is assumed to finish by software issuing reset; the
  // host cannot see completion without status polling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      step_q <= 3'd0;
      nsteps_q <= 3'd1;
      cyc_start_q <= 1'b0;
      dev_q <= nfc_pkg::DM_ARRAY;
      rdata_q <= 16'h0000;
      buf_left_q <= 6'h00;
      buf_page_q <= '0;
    end
    else
    begin
      cyc_start_q <= 1'b0;
      if (go && legal)
      begin
        busy_q <= 1'b1;
        done_q <= 1'b0;
        step_q <= 3'd0;
        nsteps_q <= steps;
        cyc_start_q <= 1'b1;
      end
      else if (apb_wr && hit_status && pwdata[nfc_pkg::ST_DONE_BIT])
        done_q <= 1'b0;
      if (cyc_done)
      begin
        if (!cur_cyc.wr)
          rdata_q <= cyc_rdata;
        if (last_step)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          dev_q <= nfc_pkg::nfc_dev_e'(dev_next);
          if (op_q == 5'(nfc_pkg::OP_BUF_START))
          begin
            buf_left_q <= 6'(wdata_q[4:0]) + 6'h01;
            buf_page_q <= addr_q;
          end
          else if (op_q == 5'(nfc_pkg::OP_BUF_WORD))
            buf_left_q <= buf_left_q - 6'h01;
        end
        else
        begin
          step_q <= step_q + 3'd1;
          cyc_start_q <= 1'b1;
        end
      end
    end
  end

  nfc_bus_cycle u_cycle
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start_q),
    .cyc(cur_cyc),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );
endmodule : nfc_host

// *** hdl/nfc_pkg.sv ***
// Purpose: Shared constants and types for the NOR flash command host
// Assumes: 100 MHz pclk, x16 flash bus, APB command registers
// Notes: All command codes and register offsets live here
package nfc_pkg;
  // ****************************************************************
  // Register map (APB byte offsets)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h14;
  // CTRL fields: [4:0] operation, bit 8 go
  localparam int CTRL_GO_BIT = 8;
  // STATUS fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  // ****************************************************************
  // Flash command codes and unlock addresses
  // ****************************************************************
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_SECSI = 8'h88;
  localparam logic [7:0] CMD_EXIT_DATA = 8'h00;
  localparam logic [11:0] ADDR_U1 = 12'h555;
  localparam logic [11:0] ADDR_U2 = 12'h2aa;
  localparam logic [11:0] ADDR_QUERY = 12'h055;
  localparam int BUF_WORDS = 32;
  // ****************************************************************
  // Bus timing (ns and derived cycles at 10 ns)
  // ****************************************************************
  localparam int CLK_NS = 10;
  localparam int T_WE_LOW_NS = 35;
  localparam int T_WE_HIGH_NS = 30;
  localparam int T_READ_NS = 110;
  localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************************************
  // Operations requested through CTRL
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_READ, OP_RESET, OP_AUTOSEL_ENTER, OP_QUERY, OP_PROGRAM,
    OP_BUF_START, OP_BUF_WORD, OP_BUF_CONFIRM, OP_ABORT_RESET,
    OP_BYPASS_ENTER, OP_BYPASS_PROG, OP_BYPASS_SECTOR_ERASE,
    OP_BYPASS_CHIP_ERASE, OP_BYPASS_EXIT, OP_CHIP_ERASE,
    OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_SECSI_ENTER,
    OP_SECSI_EXIT
  } nfc_op_e;
  // Host's view of the device state
  typedef enum logic [2:0] {
    DM_ARRAY, DM_AUTOSEL, DM_QUERY, DM_BYPASS, DM_ERASING,
    DM_SUSPENDED, DM_SECSI, DM_BUF_LOAD
  } nfc_dev_e;
  // One flash bus cycle
  typedef struct packed {
    logic wr;
    logic [25:0] addr;
    logic [15:0] data;
  } nfc_cyc_s;
endpackage : nfc_pkg

// *** sim/nfc_flash_model.sv ***
// Purpose: Behavioural flash that logs writes and answers reads
// Assumes: Host keeps strobe timing; no embedded algorithms
// Notes: Released data lines show the inverse of the last word
`timescale 1ns/1ps
module nfc_flash_model
#(
  parameter logic [15:0] MAN_ID = 16'h00c1, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h4d2b // Arbitrary value
)
(
  input wire logic [25:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_dq_oe,
  output logic [15:0] fl_dq_i,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n
);
  // ********************************
  // Command capture and decode
  // ********************************
  int nwr = 0;
  logic open_q = 1'b0;
  logic auto_q = 1'b0;
  logic [25:0] la;
  logic [15:0] ld;
  logic [15:0] last = 16'h0000;
  logic [7:0] h1 = 8'h00;
  logic [7:0] h2 = 8'h00;
  // Address taken when the later strobe falls
  always @(negedge fl_we_n or negedge fl_ce_n)
    if (!fl_we_n && !fl_ce_n)
    begin
      open_q = 1'b1;
      la = fl_addr;
    end
  // Value taken on the first rising strobe; low byte decoded only
  always @(posedge fl_we_n or posedge fl_ce_n)
    if (open_q)
    begin
      open_q = 1'b0;
      ld = fl_dq_oe ? fl_dq_o : ~last;
      nwr++;
      if (ld[7:0] == 8'hf0 || ld[7:0] == 8'h00)
        auto_q = 1'b0;
      else if (h2 == 8'haa && h1 == 8'h55 && ld[7:0] == 8'h90 &&
               la[11:0] == 12'h555)
        auto_q = 1'b1;
      h2 = h1;
      h1 = ld[7:0];
    end
  // Read answer; unselected lines never repeat the last word
  always @*
    if (!fl_oe_n && !fl_ce_n)
    begin
      if (!auto_q)
        fl_dq_i = fl_addr[15:0] ^ 16'hc3a5;
      else
        case (fl_addr[7:0])
          8'h00: fl_dq_i = MAN_ID;
          8'h01: fl_dq_i = DEV_ID;
          8'h03: fl_dq_i = 16'h0080;
          default: fl_dq_i = 16'h0000;
        endcase
      last = fl_dq_i;
    end
    else
      fl_dq_i = ~last;
endmodule : nfc_flash_model

// *** sim/nfc_host_assertions.sv ***
// Purpose: Pin-level checks on every flash cycle that nfc_host runs
// Assumes: Only the top-level ports are visible
// Notes: Bound to each nfc_host instance below
`timescale 1ns/1ps
module nfc_host_assertions
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [25:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n
);
  // ********************************
  // Flash cycle shape
  // ********************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Unlock cycles carry AA or 55 in the low byte
  wire unlock_w = fl_dq_o[7:0] == 8'haa || fl_dq_o[7:0] == 8'h55;
  // Write strobe low four cycles, then high
  sequence we_pulse_s;
    !fl_we_n [*4] ##1 fl_we_n;
  endsequence
  // Data and its drive kept after the strobe rises
  sequence data_hold_s;
    (fl_dq_oe && $stable(fl_dq_o)) [*3];
  endsequence
  we_width_a: assert property ($fell(fl_we_n) |-> we_pulse_s)
    else $error("write strobe width wrong");
  data_hold_a: assert property ($rose(fl_we_n) |-> data_hold_s)
    else $error("write data not held");
  upper_zero_a: assert property (!fl_we_n && unlock_w |->
    fl_dq_o[15:8] == 8'h00) else $error("upper byte set in unlock");
  high_addr_a: assert property (!fl_we_n && unlock_w |->
    fl_addr[25:16] == 10'h000) else $error("high address in unlock");
  wr_excl_a: assert property (!fl_we_n |->
    fl_oe_n && !fl_ce_n && fl_dq_oe) else $error("bad write strobes");
  rd_len_a: assert property ($fell(fl_oe_n) |->
    (!fl_ce_n && fl_we_n && !fl_dq_oe) [*8]) else $error("read short");
  rd_recov_a: assert property ($rose(fl_oe_n) |->
    (fl_oe_n && fl_we_n) [*3]) else $error("read recovery short");
  addr_hold_a: assert property (!fl_we_n && $past(!fl_we_n) |->
    $stable(fl_addr)) else $error("address moved in write");
endmodule : nfc_host_assertions
bind nfc_host nfc_host_assertions chk (.pclk(pclk), .presetn(presetn),
  .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
  .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));

// *** sim/nfc_host_tb_top.sv ***
// Purpose: Drives nfc_host over APB and checks the flash traffic
// Assumes: Zero-wait APB; STATUS polled for completion
// Notes: Model logs each write; don't-care address is all ones
`timescale 1ns/1ps
module nfc_host_tb_top;
  // ********************************
  // Bench signals, tasks and tests
  // ********************************
  localparam logic [25:0] LOC = 26'h0230040;
  localparam logic [25:0] ANY = 26'h3ffffff;
  localparam logic [15:0] WD = 16'h5a3c;
  localparam logic [15:0] DEV = 16'h4d2b; // Arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [25:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
  int mismatches = 0;
  int total_checks = 0;
  nfc_host dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n));
  nfc_flash_model #(.DEV_ID(DEV)) mdl (.fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One APB transfer; request held until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Runs one operation and checks the last flash write it made
  task op(input logic [4:0] o, input logic [25:0] a, input logic [15:0] d,
          input int n, input logic [25:0] ea, input logic [15:0] ed,
          input logic rf);
    int n0;
    int k;
    n0 = mdl.nwr;
    k = 0;
    apb(1'b1, nfc_pkg::REG_ADDR, {6'h00, a});
    apb(1'b1, nfc_pkg::REG_WDATA, {16'h0000, d});
    apb(1'b1, nfc_pkg::REG_CTRL, {23'h0, 1'b1, 3'h0, o});
    do
    begin
      apb(1'b0, nfc_pkg::REG_STATUS, 32'h0);
      k++;
    end
    while (k < 400 && (rd[0] !== 1'b0 || rd[2:1] == 2'b00));
    check("poll", 32'h0, {31'h0, k >= 400});
    check("refused", {31'h0, rf}, {31'h0, rd[2]});
    check("writes", n, mdl.nwr - n0);
    if (n > 0 && ea != ANY)
      check("address", {6'h00, ea}, {6'h00, mdl.la});
    if (n > 0)
      check("data", {16'h0000, ed}, {16'h0000, mdl.ld});
  endtask : op
  task rdata(input logic [15:0] e);
    apb(1'b0, nfc_pkg::REG_RDATA, 32'h0);
    check("rdata", {16'h0000, e}, rd);
  endtask : rdata
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // Free-running 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Cuts a hang short well past the expected run length
  initial
  begin
    #400000;
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    op(5'd0, LOC, WD, 0, ANY, 16'h0, 1'b0);
    rdata(LOC[15:0] ^ 16'hc3a5);
    op(5'd16, LOC, WD, 0, ANY, 16'h0, 1'b1);
    op(5'd17, LOC, WD, 0, ANY, 16'h0, 1'b1);
    op(5'd2, LOC, WD, 3, 26'h555, 16'h0090, 1'b0);
    apb(1'b0, nfc_pkg::REG_MODE, 32'h0);
    check("mode", 32'h1, rd);
    op(5'd0, 26'h1, WD, 0, ANY, 16'h0, 1'b0);
    rdata(DEV);
    op(5'd0, 26'h3, WD, 0, ANY, 16'h0, 1'b0);
    rdata(16'h0080);
    op(5'd0, 26'h2, WD, 0, ANY, 16'h0, 1'b0);
    rdata(16'h0000);
    op(5'd3, LOC, WD, 1, 26'h055, 16'h0098, 1'b0);
    op(5'd1, LOC, WD, 1, ANY, 16'h00f0, 1'b0);
    op(5'd4, LOC, WD, 4, LOC, WD, 1'b0);
    op(5'd14, LOC, WD, 6, 26'h555, 16'h0010, 1'b0);
    op(5'd1, LOC, WD, 1, ANY, 16'h00f0, 1'b0);
    op(5'd15, LOC, WD, 6, ANY, 16'h0030, 1'b0);
    op(5'd16, LOC, WD, 1, ANY, 16'h00b0, 1'b0);
    op(5'd17, LOC, WD, 1, ANY, 16'h0030, 1'b0);
    op(5'd1, LOC, WD, 1, ANY, 16'h00f0, 1'b0);
    op(5'd9, LOC, WD, 3, 26'h555, 16'h0020, 1'b0);
    op(5'd1, LOC, WD, 0, ANY, 16'h0, 1'b1);
    op(5'd10, LOC, WD, 2, LOC, WD, 1'b0);
    op(5'd11, LOC, WD, 2, 26'h0230000, 16'h0030, 1'b0);
    op(5'd12, LOC, WD, 2, ANY, 16'h0010, 1'b0);
    op(5'd13, LOC, WD, 2, ANY, 16'h0000, 1'b0);
    op(5'd18, LOC, WD, 3, 26'h555, 16'h0088, 1'b0);
    op(5'd19, LOC, WD, 4, ANY, 16'h0000, 1'b0);
    op(5'd5, LOC, 16'h0, 4, ANY, 16'h0000, 1'b0);
    op(5'd8, LOC, WD, 3, 26'h555, 16'h00f0, 1'b0);
    op(5'd5, LOC, 16'h0, 4, ANY, 16'h0000, 1'b0);
    op(5'd6, LOC + 26'h20, WD, 0, ANY, 16'h0, 1'b1);
    op(5'd6, LOC, WD, 1, LOC, WD, 1'b0);
    op(5'd7, LOC, WD, 1, ANY, 16'h0029, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", 32'h1, {31'h0, perr});
    complete_run();
  end
endmodule : nfc_host_tb_top
